// ### src/mtp_pkg.sv
// mtp_pkg: constants, modes and carriers of the mac transmit pin interface
// assumes a 250 MHz system clock and one transmit port per instance
package mtp_pkg;

  // ==========================================================================
  // clocking
  localparam int unsigned MTP_CLK_HZ      = 250_000_000;
  localparam int unsigned MTP_LINE_CLK_HZ = 25_000_000;
  // half period of the generated line clock in system cycles
  localparam int unsigned MTP_DIV_HALF    = MTP_CLK_HZ / (2 * MTP_LINE_CLK_HZ);
  localparam int unsigned MTP_DIV_W       = 4;

  // ==========================================================================
  // pin widths and symbol layout
  localparam int unsigned MTP_BUS_W   = 8;
  localparam int unsigned MTP_WORD_W  = 9;
  localparam int unsigned MTP_MII_W   = 4;
  localparam int unsigned MTP_RMII_W  = 2;
  localparam int unsigned MTP_MII_SYM  = MTP_BUS_W / MTP_MII_W;
  localparam int unsigned MTP_RMII_SYM = MTP_BUS_W / MTP_RMII_W;
  localparam int unsigned MTP_IDX_W   = 2;
  localparam logic [MTP_IDX_W-1:0] MTP_IDX_MII  = 2'h1;
  localparam logic [MTP_IDX_W-1:0] MTP_IDX_RMII = 2'h3;
  localparam logic [MTP_IDX_W-1:0] MTP_IDX_ONE  = 2'h0;
  localparam logic [MTP_BUS_W-1:0] MTP_MASK_MII  = 8'h0f;
  localparam logic [MTP_BUS_W-1:0] MTP_MASK_RMII = 8'h03;
  localparam logic [MTP_BUS_W-1:0] MTP_MASK_FULL = 8'hff;

  // ==========================================================================
  // modes and states
  typedef enum logic [1:0] {
    MTP_MODE_MII  = 2'b00,
    MTP_MODE_RMII = 2'b01,
    MTP_MODE_GMII = 2'b10,
    MTP_MODE_TBI  = 2'b11
  } mtp_mode_t;

  typedef enum logic [0:0] {
    MTP_ST_IDLE = 1'b0,
    MTP_ST_SEND = 1'b1
  } mtp_state_t;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic                  last;
    logic [MTP_WORD_W-1:0] data;
  } mtp_word_t;

  typedef struct packed {
    logic                 en;
    logic [MTP_BUS_W-1:0] data;
  } mtp_pins_t;

endpackage

// ### src/mtp_sync_edge.sv
// mtp_sync_edge: two-flop synchroniser with rising edge pulse
// assumes the input is asynchronous to clk and slow against it
`timescale 1ns/10ps
`default_nettype none
module mtp_sync_edge (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);
  logic meta;
  logic held;

  // ==========================================================================
  // first flop feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta  <= 1'b0;
      level <= 1'b0;
      held  <= 1'b0;
    end else begin
      meta  <= async_in;
      level <= meta;
      held  <= level;
    end
  end

  assign rise = level & ~held; // one cycle per rising edge
endmodule
`default_nettype wire

// ### src/mtp_tx_pins.sv
// mtp_tx_pins: transmit pin side of one mac port (mii, rmii, gmii, tbi)
// assumes a word stream from the mac core on clk and mode straps on clk;
// the mode clocks arrive as pins and are sampled, so they must be slow
// against clk (a 125 MHz gigabit clock cannot be followed at 250 MHz).
`timescale 1ns/10ps
`default_nettype none
module mtp_tx_pins
  import mtp_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire mtp_mode_t             mode,
  input  wire logic                  phy_emulation,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  input  wire mtp_word_t             in_word,
  input  wire logic                  port_tx_line_clock_i,
  output logic                       port_tx_line_clock_o,
  output logic                       port_tx_line_clock_oe_n,
  input  wire logic                  port_reduced_mode_ref_clock,
  input  wire logic                  port_gigabit_tx_clock,
  output logic [MTP_BUS_W-1:0]       port_tx_data_bus,
  output logic                       port_tx_frame_enable
);

  // refuse a divider that the counter cannot reach or that leaves no low half
  if (MTP_DIV_HALF < 2 || MTP_DIV_HALF >= (1 << MTP_DIV_W)) begin : g_div_check
    $error("line clock divider out of range");
  end

  // ==========================================================================
  // clock pins
  logic                 line_rise;
  logic                 ref_rise;
  logic                 gtx_rise;
  logic [MTP_DIV_W-1:0] div_cnt;
  logic                 gen_rise;
  logic                 mode_edge;

  mtp_sync_edge u_line (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (port_tx_line_clock_i),
    .level    (),
    .rise     (line_rise)
  );
  mtp_sync_edge u_ref (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (port_reduced_mode_ref_clock),
    .level    (),
    .rise     (ref_rise)
  );
  mtp_sync_edge u_gtx (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (port_gigabit_tx_clock),
    .level    (),
    .rise     (gtx_rise)
  );

  // 25 MHz divider, run only while emulating the phy
  always_ff @(posedge clk) begin
    if (!rst_n || !phy_emulation) begin
      div_cnt              <= '0;
      port_tx_line_clock_o <= 1'b0;
    end else if (div_cnt == MTP_DIV_W'(MTP_DIV_HALF - 1)) begin
      div_cnt              <= '0;
      port_tx_line_clock_o <= ~port_tx_line_clock_o;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // drive pin only in phy emulation; oe is low while driving
  always_ff @(posedge clk) begin
    if (!rst_n) port_tx_line_clock_oe_n <= 1'b1;
    else        port_tx_line_clock_oe_n <= ~phy_emulation;
  end

  // one cycle after our own rise, so data never moves with the clock pin
  assign gen_rise = port_tx_line_clock_o && div_cnt == '0 && phy_emulation;

  // pick the clock that times the current mode
  always_comb begin
    case (mode)
      MTP_MODE_MII:  mode_edge = phy_emulation ? gen_rise : line_rise;
      MTP_MODE_RMII: mode_edge = ref_rise;
      MTP_MODE_GMII: mode_edge = gtx_rise;
      MTP_MODE_TBI:  mode_edge = gtx_rise;
      default:       mode_edge = 1'b0;
    endcase
  end

  // ==========================================================================
  // symbol serialiser
  mtp_state_t           state;
  logic [MTP_BUS_W-1:0] shreg;
  logic [MTP_IDX_W-1:0] idx;
  logic                 word_last;
  logic                 last_sent;
  logic [MTP_BUS_W-1:0] mask;
  logic [MTP_IDX_W-1:0] first_idx;
  logic                 accept;
  mtp_pins_t            pins;

  always_comb begin
    case (mode)
      MTP_MODE_MII: begin
        mask      = MTP_MASK_MII;
        first_idx = MTP_IDX_MII;
      end
      MTP_MODE_RMII: begin
        mask      = MTP_MASK_RMII;
        first_idx = MTP_IDX_RMII;
      end
      default: begin
        mask      = MTP_MASK_FULL;
        first_idx = MTP_IDX_ONE;
      end
    endcase
  end

  // a new word is taken only on a mode edge once the byte is used up
  assign in_ready = mode_edge && idx == '0;
  assign accept   = in_valid && in_ready;

  // frame state: outside tbi, enable falls only after the last word's last symbol
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= MTP_ST_IDLE;
    end else if (accept) begin
      state <= MTP_ST_SEND;
    end else if (mode_edge && idx == '0 && word_last) begin
      state <= MTP_ST_IDLE;
    end
  end

  // remember that the final symbol has gone out
  always_ff @(posedge clk) begin
    if (!rst_n)         last_sent <= 1'b0;
    else if (mode_edge) last_sent <= (idx == '0) && !accept && word_last;
  end

  // byte shifter, low symbol first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shreg     <= '0;
      idx       <= '0;
      word_last <= 1'b0;
    end else if (accept) begin
      shreg     <= in_word.data[MTP_BUS_W-1:0];
      idx       <= first_idx;
      word_last <= in_word.last;
    end else if (mode_edge && idx != '0) begin
      shreg <= (mode == MTP_MODE_MII) ? (shreg >> MTP_MII_W) : (shreg >> MTP_RMII_W);
      idx   <= idx - 1'b1;
    end else if (mode_edge && word_last) begin
      word_last <= 1'b0;
    end
  end

  // launched pins; underrun inside a frame repeats the last symbol
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pins <= '0;
    end else if (accept) begin
      pins.data <= in_word.data[MTP_BUS_W-1:0] & mask;
      if (mode == MTP_MODE_TBI) pins.en <= in_word.data[MTP_BUS_W];
      else                      pins.en <= 1'b1;
    end else if (mode_edge && idx != '0) begin
      if (mode == MTP_MODE_MII) pins.data <= (shreg >> MTP_MII_W) & mask;
      else                      pins.data <= (shreg >> MTP_RMII_W) & mask;
    end else if (mode_edge && idx == '0 && word_last) begin
      pins.en <= 1'b0;
    end else begin
      pins.data <= pins.data & mask;
    end
  end

  assign port_tx_data_bus     = pins.data;
  assign port_tx_frame_enable = pins.en;

  // ==========================================================================
  // checks
  property p_line_clk_rate;
    @(posedge clk) disable iff (!rst_n)
      phy_emulation && $past(phy_emulation) && div_cnt == MTP_DIV_W'(MTP_DIV_HALF - 1)
      |=> port_tx_line_clock_o != $past(port_tx_line_clock_o);
  endproperty
  a_line_clk_rate: assert property (p_line_clk_rate)
    else $error("line clock did not toggle at half period");

  property p_line_clk_dir;
    @(posedge clk) disable iff (!rst_n)
      $changed(phy_emulation) |=> port_tx_line_clock_oe_n == !$past(phy_emulation);
  endproperty
  a_line_clk_dir: assert property (p_line_clk_dir)
    else $error("line clock direction wrong");

  property p_rmii_bits;
    @(posedge clk) disable iff (!rst_n)
      mode == MTP_MODE_RMII && $past(mode) == MTP_MODE_RMII |-> port_tx_data_bus[7:2] == '0;
  endproperty
  a_rmii_bits: assert property (p_rmii_bits)
    else $error("rmii drives upper bits");

  property p_launch_on_edge;
    @(posedge clk) disable iff (!rst_n)
      $stable(mode) && $changed(port_tx_frame_enable) |-> $past(mode_edge);
  endproperty
  a_launch_on_edge: assert property (p_launch_on_edge)
    else $error("enable moved without a mode clock edge");

  property p_enable_rise;
    @(posedge clk) disable iff (!rst_n)
      mode != MTP_MODE_TBI && $rose(port_tx_frame_enable) |-> $past(accept);
  endproperty
  a_enable_rise: assert property (p_enable_rise)
    else $error("frame enable rose without a word");

  property p_enable_fall;
    @(posedge clk) disable iff (!rst_n)
      mode != MTP_MODE_TBI && $stable(mode) && $fell(port_tx_frame_enable) |-> last_sent;
  endproperty
  a_enable_fall: assert property (p_enable_fall)
    else $error("frame enable fell before last symbol");

  // outside tbi the enable pin is the frame state itself
  property p_enable_state;
    @(posedge clk) disable iff (!rst_n)
      mode != MTP_MODE_TBI |-> port_tx_frame_enable == (state == MTP_ST_SEND);
  endproperty
  a_enable_state: assert property (p_enable_state)
    else $error("frame enable does not follow frame state");

  property p_tbi_bit_nine;
    @(posedge clk) disable iff (!rst_n)
      mode == MTP_MODE_TBI && accept ##1 mode == MTP_MODE_TBI
      |-> port_tx_frame_enable == $past(in_word.data[MTP_BUS_W]);
  endproperty
  a_tbi_bit_nine: assert property (p_tbi_bit_nine)
    else $error("tbi ninth bit not on enable pin");

  property p_idle_hold;
    @(posedge clk) disable iff (!rst_n)
      mode == MTP_MODE_MII && $stable(mode) && $past(mode, 2) == MTP_MODE_MII &&
      !port_tx_frame_enable && $past(!pins.en)
      |-> $stable(port_tx_data_bus) && port_tx_data_bus[7:4] == '0;
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("idle data moved or upper bits set");

endmodule
`default_nettype wire

// ### tb/mtp_phy_model.sv
// mtp_phy_model: behavioural phy on the transmit pins, records each symbol
// assumes the bench raises run only while a frame is under way
`timescale 1ns/10ps
`default_nettype none
module mtp_phy_model
  import mtp_pkg::*;
#(
  parameter int HALF_NS = 80
) (
  input  wire logic      run,
  input  wire logic      dev_clk,
  input  wire mtp_mode_t mode,
  input  wire mtp_pins_t pins,
  output logic           line_clk,
  output logic           ref_clk,
  output logic           gtx_clk
);
  // ==========================================================================
  // mode clock, still between frames so the block sees no stray edge
  logic      pin_clk;
  mtp_pins_t cap [0:255];
  int        n;
  initial begin
    pin_clk = 1'b0;
    n = 0;
    forever begin
      wait (run);
      #(HALF_NS + 1) pin_clk = 1'b1;
      #(HALF_NS - 1) pin_clk = 1'b0;
    end
  end
  // only the chosen mode's clock moves; the phy sources it in mac mode
  assign line_clk = (mode == MTP_MODE_MII) & pin_clk;
  assign ref_clk  = (mode == MTP_MODE_RMII) & pin_clk;
  assign gtx_clk  = mode[1] & pin_clk;
  // sample the pins on the rising edge, as a phy would; in emulation the
  // block sources the line clock and the model samples on that instead
  always @(posedge pin_clk or posedge dev_clk) begin
    cap[n[7:0]] = pins;
    n = n + 1;
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// tb_top: self-checking bench for the transmit pin block
// assumes the phy model closes the far side and sources the mode clocks
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import mtp_pkg::*;
  logic                 clk = 1'b0;
  logic                 rst_n;
  mtp_mode_t            mode;
  logic                 phy_emulation;
  logic                 in_valid;
  logic                 in_ready;
  mtp_word_t            in_word;
  logic                 run;
  logic                 line_o;
  logic                 oe_n;
  logic                 phy_line;
  logic                 line_wire;
  logic                 dev_line;
  logic                 ref_clk;
  logic                 gtx_clk;
  logic [MTP_BUS_W-1:0] data;
  logic                 en;
  int                   failures = 0;
  int                   check_count = 0;
  int                   cycles = 0;
  // 160 ns link period counted in 4 ns clocks
  localparam int        LINK_CYC = 40;

  // ==========================================================================
  // clock, pin resolution and instances
  always #2 clk = ~clk;
  // the line clock pin is whoever has it enabled
  assign line_wire = oe_n ? phy_line : line_o;
  // the clock the block drives, as the phy sees it on the pin
  assign dev_line  = !oe_n & line_o;

  mtp_tx_pins uut (
    .clk(clk), .rst_n(rst_n), .mode(mode), .phy_emulation(phy_emulation),
    .in_valid(in_valid), .in_ready(in_ready), .in_word(in_word),
    .port_tx_line_clock_i(line_wire), .port_tx_line_clock_o(line_o),
    .port_tx_line_clock_oe_n(oe_n), .port_reduced_mode_ref_clock(ref_clk),
    .port_gigabit_tx_clock(gtx_clk), .port_tx_data_bus(data),
    .port_tx_frame_enable(en)
  );
  mtp_phy_model phy (
    .run(run), .dev_clk(dev_line), .mode(mode), .pins({en, data}),
    .line_clk(phy_line), .ref_clk(ref_clk), .gtx_clk(gtx_clk)
  );

  // ==========================================================================
  // checking and closing
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // a hang is cut short well past the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  // ==========================================================================
  // scenarios
  task automatic emulate();
    int j;
    int gap;
    phy_emulation <= 1'b1;
    for (j = 0; j < 2; j++) begin
      gap = 0;
      while (line_o !== 1'b0 && gap < 60) begin @(negedge clk); gap++; end
      while (line_o !== 1'b1 && gap < 60) begin @(negedge clk); gap++; end
    end
    check("line clock period", 9'(gap), 9'(2 * MTP_DIV_HALF));
    check("drive enable", {8'h00, oe_n}, 9'h000);
    @(posedge clk);
    phy_emulation <= 1'b0;
    repeat (4) @(negedge clk);
    check("released pin", {7'h00, oe_n, line_o}, 9'h002);
  endtask

  task automatic send_frame(input mtp_mode_t m, input logic emu);
    logic [8:0] w [0:2];
    logic [7:0] s;
    int         nsym;
    int         first;
    int         j;
    int         k;
    w[0] = 9'h1a5;
    w[1] = 9'h03c;
    w[2] = 9'h1f0;
    s = 8'h00;
    nsym = (m == MTP_MODE_MII) ? 2 : (m == MTP_MODE_RMII) ? 4 : 1;
    @(posedge clk);
    mode <= m;
    phy_emulation <= emu;
    // the model's clock runs only when the phy sources it
    run <= !emu;
    // words back to back, each held until taken
    for (j = 0; j < 3; j++) begin
      in_valid <= 1'b1;
      in_word <= '{last: (j == 2), data: w[j]};
      k = 0;
      do begin @(negedge clk); k++; end while (in_ready !== 1'b1 && k < 500);
      // one word per symbol count of mode clock periods
      if (j > 0)
        check("ready spacing", 9'(k),
              9'(nsym * (emu ? 2 * MTP_DIV_HALF : LINK_CYC)));
      @(posedge clk);
      if (j == 0) first = phy.n;
    end
    in_valid <= 1'b0;
    k = 0;
    while (phy.n < first + 3 * nsym + 1 && k < 2000) begin @(posedge clk); k++; end
    run <= 1'b0;
    phy_emulation <= 1'b0;
    // let the model's clock finish its high half, so a mode change makes no edge
    repeat (25) @(posedge clk);
    check("enable before frame", {8'h00, phy.cap[first - 1].en}, 9'h000);
    for (j = 0; j < 3; j++) begin
      for (k = 0; k < nsym; k++) begin
        s = w[j][7:0] >> (k * (8 / nsym));
        if (nsym > 1) s = s & ((8'h01 << (8 / nsym)) - 8'h01);
        check("data", {1'b0, phy.cap[first + j * nsym + k].data}, {1'b0, s});
        check("enable", {8'h00, phy.cap[first + j * nsym + k].en},
              {8'h00, (m == MTP_MODE_TBI) ? w[j][8] : 1'b1});
      end
    end
    check("enable after last", {8'h00, phy.cap[first + 3 * nsym].en}, 9'h000);
    check("data holds", {1'b0, phy.cap[first + 3 * nsym].data}, {1'b0, s});
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    mode = MTP_MODE_MII;
    phy_emulation = 1'b0;
    in_valid = 1'b0;
    in_word = '0;
    run = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("pins in reset", {en, data}, 9'h000);
    check("pin drive in reset", {7'h00, oe_n, line_o}, 9'h002);
    @(posedge clk);
    rst_n <= 1'b1;
    emulate();
    send_frame(MTP_MODE_MII, 1'b1);
    send_frame(MTP_MODE_MII, 1'b0);
    send_frame(MTP_MODE_RMII, 1'b0);
    send_frame(MTP_MODE_GMII, 1'b0);
    send_frame(MTP_MODE_TBI, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
